//--- otsm_consts.vh
// Constants, register map and timing for the car speed supervision block
// Overview of operation
// (RULE_01) Overspeed threshold fixed at 150 fpm, any direction
// (RULE_02) Tuned and enabled: speed relays on after 1s
// (RULE_03) Zone relays on outside zone or doors closed
// (RULE_04) Zone relays drop: doors open 1s, or inspection
// (RULE_05) Zone dropped and over 150 fpm: overspeed fault
// (RULE_06) Overspeed fault lights trip, latches monitor relay
// (RULE_07) Overspeed fault survives power loss
// (RULE_08) Overspeed fault cleared by reset button or retune
// (RULE_09) Overspeed calibrate switch holds speed relays on
// (RULE_10) Monitor relay on above 150, off below 50
// (RULE_11) Processor logs overspeed: feedbacks low, flag high
// (RULE_12) Terminal threshold 90% when contract above 200 fpm
// (RULE_13) Terminal zone relays on while both switches high
// (RULE_14) Speed relays drop above 90%, return below
// (RULE_15) Zone relays held until a terminal switch opens
// (RULE_16) Zone drop during terminal overspeed: terminal fault
// (RULE_17) Terminal fault lights trip, survives power loss
// (RULE_18) Terminal fault cleared by retune or normal reset
// (RULE_19) Defeated terminal holds zone; speed relays follow
// (RULE_20) Overspeed retune invalidates terminal tuning
// (RULE_21) Processor logs terminal fault: feedbacks low, flag low
// (RULE_22) Processor flags switches not opening at terminal
// (RULE_23) Speed from stripe interval in clock cycles
`ifndef OTSM_CONSTS_VH
`define OTSM_CONSTS_VH

`define OTSM_CLK_PERIOD_NS  10
`define OTSM_POWERUP_NS     1000000000
`define OTSM_DOOR_OPEN_NS   1000000000

`define OTSM_OS_FPM         150
`define OTSM_LOW_FPM        50
`define OTSM_TS_PCT         90
`define OTSM_TS_MIN_FPM     200

`define OTSM_AW             8
`define OTSM_CNT_W          24
`define OTSM_TMR_W          27

`define OTSM_CTRL_ADDR      8'h00
`define OTSM_OS_THR_ADDR    8'h04
`define OTSM_LOW_THR_ADDR   8'h08
`define OTSM_TS_THR_ADDR    8'h0C
`define OTSM_STATUS_ADDR    8'h10
`define OTSM_PERIOD_ADDR    8'h14

`define OTSM_CTRL_HIGH_BIT  0
`define OTSM_THR_RST        24'hFFFFFF

`define OTSM_ST_OS_TUNED    0
`define OTSM_ST_TS_TUNED    1
`define OTSM_ST_OS_FAULT    2
`define OTSM_ST_TS_FAULT    3
`define OTSM_ST_LSM         4
`define OTSM_ST_SPEED_REL   5
`define OTSM_ST_ZONE_REL    6
`define OTSM_ST_OVER_OS     7
`define OTSM_ST_OVER_TS     8
`define OTSM_ST_PWR_DONE    9

`endif

//--- otsm_ctrl_model.sv
// Controller processor model: logs faults from relay feedback and flag
`timescale 1ns/1ps
module otsm_ctrl_model (
    input wire ref_clk,
    input wire rst_b,
    input wire checkOn,
    input wire speedRelayFeedback,
    input wire zoneRelayFeedback,
    input wire speedFlagInput,
    input wire stoppedAtTerminal,
    input wire upTerminalSwitchInput,
    input wire downTerminalSwitchInput,
    output reg osLogged,
    output reg tsLogged,
    output reg switchFault
);
    // Stopped at a terminal landing, one terminal switch must be open
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            switchFault <= 1'b0;
        else if (stoppedAtTerminal && upTerminalSwitchInput
                 && downTerminalSwitchInput)
            switchFault <= 1'b1;
    end
    // Only judged while armed: at power-up every relay is legitimately off
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            osLogged <= 1'b0;
            tsLogged <= 1'b0;
        end else if (checkOn && !speedRelayFeedback && !zoneRelayFeedback) begin
            if (speedFlagInput)
                osLogged <= 1'b1;
            else
                tsLogged <= 1'b1;
        end
    end
endmodule

//--- otsm_monitor.v
// Car speed supervision: overspeed and terminal slowdown relay logic
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "otsm_consts.vh"

module otsm_monitor #(
    parameter POWERUP_CYC   = `OTSM_POWERUP_NS / `OTSM_CLK_PERIOD_NS,
    parameter DOOR_OPEN_CYC = `OTSM_DOOR_OPEN_NS / `OTSM_CLK_PERIOD_NS
) (
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    input  wire        photoIn,
    input  wire        externalEnableInput,
    input  wire        normalMode,
    input  wire        inspectionMode,
    input  wire        doorZone,
    input  wire        doorsClosed,
    input  wire        safeInput,
    input  wire        upTerminalSwitchInput,
    input  wire        downTerminalSwitchInput,
    input  wire        overspeedCalSwitch,
    input  wire        terminalCalSwitch,
    input  wire        overspeedResetButton,
    input  wire        terminalResetButton,
    input  wire        storedOverspeedFault,
    input  wire        storedTerminalFault,
    output reg         speedSafetyRelayA,
    output reg         speedSafetyRelayB,
    output reg         zoneSafetyRelayA,
    output reg         zoneSafetyRelayB,
    output reg         lowSpeedMonitorRelay,
    output reg         overspeedTripIndicator,
    output reg         terminalTripIndicator
);

    // Timer end points are worked out as integers, then cut on purpose
    localparam integer PWR_LAST_I  = POWERUP_CYC - 1;
    localparam integer DOOR_LAST_I = DOOR_OPEN_CYC - 1;
    localparam [`OTSM_TMR_W-1:0] PWR_LAST  = PWR_LAST_I[`OTSM_TMR_W-1:0];
    localparam [`OTSM_TMR_W-1:0] DOOR_LAST = DOOR_LAST_I[`OTSM_TMR_W-1:0];
    localparam [`OTSM_CNT_W-1:0] CNT_MAX   = `OTSM_THR_RST;

    // Reset release through two flops
    reg rstSync1_q;
    reg rstSync2_q;
    wire rstN;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end

    assign rstN = rstSync2_q;

    // Bus slave: address phase captured, write done in data phase
    reg                 wrPend_q;
    reg [`OTSM_AW-1:0]  wrAddr_q;
    reg                 ctrlHigh_q;
    reg [`OTSM_CNT_W-1:0] osThr_q;
    reg [`OTSM_CNT_W-1:0] lowThr_q;
    reg [`OTSM_CNT_W-1:0] tsThr_q;
    reg [31:0]          rdMux;
    wire                addrPhase;
    wire                osRetune;
    wire                tsRetune;
    wire [31:0]         statusWord;
    reg [`OTSM_CNT_W-1:0] period_q;

    // hsize is not decoded: every register is one whole word
    assign addrPhase = hsel & htrans[1] & hready;
    assign osRetune  = wrPend_q & (wrAddr_q == `OTSM_OS_THR_ADDR);
    assign tsRetune  = wrPend_q & (wrAddr_q == `OTSM_TS_THR_ADDR);

    always @* begin
        case (haddr[`OTSM_AW-1:0])
            `OTSM_CTRL_ADDR:    rdMux = {31'h0, ctrlHigh_q};
            `OTSM_OS_THR_ADDR:  rdMux = {8'h00, osThr_q};
            `OTSM_LOW_THR_ADDR: rdMux = {8'h00, lowThr_q};
            `OTSM_TS_THR_ADDR:  rdMux = {8'h00, tsThr_q};
            `OTSM_STATUS_ADDR:  rdMux = statusWord;
            `OTSM_PERIOD_ADDR:  rdMux = {8'h00, period_q};
            default:            rdMux = 32'h0;
        endcase
    end

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0;
            wrPend_q   <= 1'b0;
            wrAddr_q   <= 8'h00;
            ctrlHigh_q <= 1'b0;
            osThr_q    <= `OTSM_THR_RST;
            lowThr_q   <= `OTSM_THR_RST;
            tsThr_q    <= `OTSM_THR_RST;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_q  <= addrPhase & hwrite;
            if (addrPhase) begin
                wrAddr_q <= haddr[`OTSM_AW-1:0];
            end
            if (addrPhase & ~hwrite) begin
                hrdata <= rdMux;
            end
            if (wrPend_q) begin
                case (wrAddr_q)
                    `OTSM_CTRL_ADDR:
                        ctrlHigh_q <= hwdata[`OTSM_CTRL_HIGH_BIT];
                    `OTSM_OS_THR_ADDR:  osThr_q <= hwdata[23:0];
                    `OTSM_LOW_THR_ADDR: lowThr_q <= hwdata[23:0];
                    `OTSM_TS_THR_ADDR:  tsThr_q <= hwdata[23:0];
                    default: ;
                endcase
            end
        end
    end

    // Stripe interval measurement; a live count longer than the last
    // interval means the car has slowed since, so both must be short
    reg                   photo_q;
    reg                   photoPrimed_q;
    reg [`OTSM_CNT_W-1:0] cnt_q;
    wire                  stripeEdge;
    wire                  overOs;
    wire                  underLow;
    wire                  overTs;

    // First sample after reset only primes the detector: no false edge
    assign stripeEdge = photoPrimed_q & (photoIn ^ photo_q);

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            photo_q  <= 1'b0;
            photoPrimed_q <= 1'b0;
            cnt_q    <= 24'h000000;
            period_q <= `OTSM_THR_RST;
        end else begin
            photo_q <= photoIn;
            photoPrimed_q <= 1'b1;
            if (stripeEdge) begin
                period_q <= cnt_q; // see (RULE_23)
                cnt_q    <= 24'h000000;
            end else if (cnt_q != CNT_MAX) begin
                cnt_q <= cnt_q + 24'h000001;
            end
        end
    end

    // No direction is used: the interval is the same both ways
    assign overOs   = (period_q < osThr_q) &
                      (cnt_q < osThr_q); // see (RULE_01)
    assign underLow = (period_q > lowThr_q) | (cnt_q > lowThr_q);
    assign overTs   = (period_q < tsThr_q) &
                      (cnt_q < tsThr_q); // see (RULE_12)

    // Tuning state and power-up delay
    reg                   osTuned_q;
    reg                   tsTuned_q;
    reg                   pwrDone_q;
    reg [`OTSM_TMR_W-1:0] pwrCnt_q;
    reg                   nvLoaded_q;

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            osTuned_q <= 1'b0;
            tsTuned_q <= 1'b0;
            pwrDone_q <= 1'b0;
            pwrCnt_q  <= 27'h0;
        end else begin
            if (osRetune) begin
                osTuned_q <= 1'b1;
            end
            if (osRetune) begin
                tsTuned_q <= 1'b0; // see (RULE_20)
            end else if (tsRetune) begin
                tsTuned_q <= 1'b1;
            end
            if (pwrCnt_q == PWR_LAST) begin
                pwrDone_q <= 1'b1; // see (RULE_02)
            end else begin
                pwrCnt_q <= pwrCnt_q + 27'h1;
            end
        end
    end

    // Door-open timer on normal operation in the door zone
    reg [`OTSM_TMR_W-1:0] doorCnt_q;
    reg                   doorRelease_q;
    wire                  doorsOpenInZone;

    assign doorsOpenInZone = normalMode & doorZone & ~doorsClosed;

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            doorCnt_q     <= 27'h0;
            doorRelease_q <= 1'b0;
        end else if (!doorsOpenInZone) begin
            doorCnt_q     <= 27'h0;
            doorRelease_q <= 1'b0;
        end else if (safeInput && !doorRelease_q) begin
            // Drive dropped before time ran out: the second starts over
            doorCnt_q <= 27'h0;
        end else if (!doorRelease_q) begin
            if (doorCnt_q == DOOR_LAST) begin
                doorRelease_q <= 1'b1; // see (RULE_04)
            end else begin
                doorCnt_q <= doorCnt_q + 27'h1;
            end
        end
    end

    // Relay decisions
    wire osZoneOn;
    wire osGuard;
    wire tsActive;
    wire tsDefeat;
    wire tsZoneOn;
    wire osTrip;
    wire tsTrip;
    wire speedOn;
    wire zoneOn;
    reg  osFault_q;
    reg  tsFault_q;

    // Inspection and timed door release both drop the zone pair
    assign osZoneOn = normalMode & ~inspectionMode &
                      ~doorRelease_q; // see (RULE_03)
    assign osGuard  = inspectionMode | doorRelease_q;
    assign osTrip   = osTuned_q & ~overspeedCalSwitch &
                      osGuard & overOs; // see (RULE_05)

    assign tsActive = tsTuned_q & ctrlHigh_q; // see (RULE_12)
    assign tsDefeat = terminalCalSwitch | inspectionMode; // see (RULE_19)
    assign tsZoneOn = ~tsActive | tsDefeat |
                      (normalMode & upTerminalSwitchInput &
                       downTerminalSwitchInput); // see (RULE_13)
    // Terminal switch opening while still above 90% is the trip
    assign tsTrip   = tsActive & ~tsDefeat & overTs &
                      ~(upTerminalSwitchInput & downTerminalSwitchInput); // see (RULE_16)

    // Calibrate switch overrides speed, not a terminal overspeed
    assign speedOn = pwrDone_q & externalEnableInput & osTuned_q &
                     (overspeedCalSwitch | ~osFault_q) &
                     ~(tsActive & overTs); // see (RULE_09)
    assign zoneOn  = pwrDone_q & osTuned_q & osZoneOn & tsZoneOn &
                     ~tsFault_q; // see (RULE_15)

    // Faults: stored copy restored once after reset; set beats clear
    reg osRstBtn_q;
    reg tsRstBtn_q;
    wire osClear;
    wire tsClear;

    // A held button clears once; it takes a fresh press to clear again
    assign osClear = (overspeedResetButton & ~osRstBtn_q) |
                     osRetune; // see (RULE_08)
    assign tsClear = (terminalResetButton & ~tsRstBtn_q & normalMode) |
                     tsRetune | osRetune; // see (RULE_18)

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            nvLoaded_q <= 1'b0;
            osFault_q  <= 1'b0;
            tsFault_q  <= 1'b0;
            osRstBtn_q <= 1'b0;
            tsRstBtn_q <= 1'b0;
        end else begin
            nvLoaded_q <= 1'b1;
            osRstBtn_q <= overspeedResetButton;
            tsRstBtn_q <= terminalResetButton;
            if (!nvLoaded_q) begin
                osFault_q <= storedOverspeedFault; // see (RULE_07)
                tsFault_q <= storedTerminalFault; // see (RULE_17)
            end else begin
                if (osTrip) begin
                    osFault_q <= 1'b1;
                end else if (osClear) begin
                    osFault_q <= 1'b0;
                end
                if (tsTrip) begin
                    tsFault_q <= 1'b1;
                end else if (tsClear) begin
                    tsFault_q <= 1'b0;
                end
            end
        end
    end

    // Registered outputs; both relays of a pair switch together
    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            speedSafetyRelayA      <= 1'b0;
            speedSafetyRelayB      <= 1'b0;
            zoneSafetyRelayA       <= 1'b0;
            zoneSafetyRelayB       <= 1'b0;
            lowSpeedMonitorRelay   <= 1'b0;
            overspeedTripIndicator <= 1'b0;
            terminalTripIndicator  <= 1'b0;
        end else begin
            speedSafetyRelayA <= speedOn & ~osTrip; // see (RULE_14)
            speedSafetyRelayB <= speedOn & ~osTrip;
            zoneSafetyRelayA  <= zoneOn & ~tsTrip;
            zoneSafetyRelayB  <= zoneOn & ~tsTrip;
            // A latched fault holds the monitor relay even if tuning is lost
            if (osFault_q | (osTuned_q & overOs)) begin
                lowSpeedMonitorRelay <= 1'b1; // see (RULE_10)
            end else if (underLow | ~osTuned_q) begin
                lowSpeedMonitorRelay <= 1'b0;
            end
            overspeedTripIndicator <= osFault_q; // see (RULE_06)
            terminalTripIndicator  <= tsFault_q;
        end
    end

    assign statusWord = {22'h0,
                         pwrDone_q,
                         overTs,
                         overOs,
                         zoneSafetyRelayA,
                         speedSafetyRelayA,
                         lowSpeedMonitorRelay,
                         tsFault_q,
                         osFault_q,
                         tsTuned_q,
                         osTuned_q};

endmodule

//--- otsm_monitor_props.sv
// Port-level checker for the car speed supervision block
`timescale 1ns/1ps
module otsm_monitor_props (
    input wire        ref_clk,
    input wire        rst_b,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hreadyout,
    input wire        hresp,
    input wire        normalMode,
    input wire        inspectionMode,
    input wire        overspeedCalSwitch,
    input wire        overspeedResetButton,
    input wire        terminalResetButton,
    input wire        speedSafetyRelayA,
    input wire        speedSafetyRelayB,
    input wire        zoneSafetyRelayA,
    input wire        zoneSafetyRelayB,
    input wire        lowSpeedMonitorRelay,
    input wire        overspeedTripIndicator,
    input wire        terminalTripIndicator
);
    wire wrTaken = hsel && htrans[1] && hwrite;
    wire osClr = overspeedResetButton || (wrTaken && haddr[7:0] == 8'h04);
    wire tsClr = (terminalResetButton && normalMode) || osClr
        || (wrTaken && haddr[7:0] == 8'h0C);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    relay_pair_a: assert property (
        speedSafetyRelayA == speedSafetyRelayB
        && zoneSafetyRelayA == zoneSafetyRelayB) else $error("relay pair split");
    trip_drops_speed_a: assert property (
        overspeedTripIndicator && $past(overspeedTripIndicator)
        && !$past(overspeedCalSwitch) && !$past(overspeedCalSwitch, 2)
        |-> !speedSafetyRelayA) else $error("speed relays held in fault");
    trip_latches_lsm_a: assert property (
        overspeedTripIndicator && $past(overspeedTripIndicator)
        |-> lowSpeedMonitorRelay) else $error("monitor relay not latched");
    insp_zone_off_a: assert property (
        $past(inspectionMode) && $past(inspectionMode, 2)
        |-> !zoneSafetyRelayA) else $error("zone relays on in inspection");
    zone_needs_normal_a: assert property (
        $rose(zoneSafetyRelayA) |-> $past(normalMode))
        else $error("zone relays rose off normal");
    os_clear_cause_a: assert property (
        $fell(overspeedTripIndicator)
        |-> $past(osClr) || $past(osClr, 2) || $past(osClr, 3))
        else $error("overspeed fault cleared without cause");
    ts_clear_cause_a: assert property (
        $fell(terminalTripIndicator)
        |-> $past(tsClr) || $past(tsClr, 2) || $past(tsClr, 3))
        else $error("terminal fault cleared without cause");
    lsm_fault_hold_a: assert property (
        $fell(lowSpeedMonitorRelay) |-> !overspeedTripIndicator)
        else $error("monitor relay dropped in fault");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
endmodule

bind otsm_monitor otsm_monitor_props chk_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hreadyout(hreadyout), .hresp(hresp), .normalMode(normalMode),
    .inspectionMode(inspectionMode), .overspeedCalSwitch(overspeedCalSwitch),
    .overspeedResetButton(overspeedResetButton),
    .terminalResetButton(terminalResetButton),
    .speedSafetyRelayA(speedSafetyRelayA), .speedSafetyRelayB(speedSafetyRelayB),
    .zoneSafetyRelayA(zoneSafetyRelayA), .zoneSafetyRelayB(zoneSafetyRelayB),
    .lowSpeedMonitorRelay(lowSpeedMonitorRelay),
    .overspeedTripIndicator(overspeedTripIndicator),
    .terminalTripIndicator(terminalTripIndicator));

//--- tb_top.sv
// Self-checking bench for the car speed supervision block
`timescale 1ns/1ps
module tb_top;
    localparam int PWR = 50;
    localparam int DOOR = 40;
    reg        ref_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg [1:0]  htrans = 2'h0;
    reg [2:0]  hsize = 3'h2;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0;
    reg        photoIn = 0, enIn = 0, normalMode = 0, inspMode = 0, doorZone = 0;
    reg        doorsClosed = 1, safeIn = 1, upSw = 1, dnSw = 1, osCal = 0;
    reg        tsCal = 0, osRst = 0, tsRst = 0, storedOs = 0, checkOn = 0;
    reg        atTerm = 0;
    wire       hreadyOut, hresp, spA, spB, znA, znB, speed_flag_input, osTrip, tsTrip;
    wire       osLog, tsLog, swFault;
    integer    photoCnt = 0;
    wire [31:0] hrdata;
    integer    err_count = 0, comparisons = 0, halfPer = 100;
    integer    seed = 32'h999B0A3A, mOsT = 0, mOsF = 0, mTsT = 0;
    logic [31:0] rd;

    otsm_monitor #(.POWERUP_CYC(PWR), .DOOR_OPEN_CYC(DOOR)) dut_u (
        .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyOut), .hreadyout(hreadyOut), .hresp(hresp),
        .hrdata(hrdata), .photoIn(photoIn), .externalEnableInput(enIn),
        .normalMode(normalMode), .inspectionMode(inspMode),
        .doorZone(doorZone), .doorsClosed(doorsClosed), .safeInput(safeIn),
        .upTerminalSwitchInput(upSw), .downTerminalSwitchInput(dnSw),
        .overspeedCalSwitch(osCal), .terminalCalSwitch(tsCal),
        .overspeedResetButton(osRst), .terminalResetButton(tsRst),
        .storedOverspeedFault(storedOs), .storedTerminalFault(tsTrip),
        .speedSafetyRelayA(spA), .speedSafetyRelayB(spB),
        .zoneSafetyRelayA(znA), .zoneSafetyRelayB(znB),
        .lowSpeedMonitorRelay(speed_flag_input), .overspeedTripIndicator(osTrip),
        .terminalTripIndicator(tsTrip));
    otsm_ctrl_model ctrl_u (.ref_clk(ref_clk), .rst_b(rst_b),
        .checkOn(checkOn), .speedRelayFeedback(spA),
        .zoneRelayFeedback(znA), .speedFlagInput(speed_flag_input),
        .stoppedAtTerminal(atTerm), .upTerminalSwitchInput(upSw),
        .downTerminalSwitchInput(dnSw), .osLogged(osLog),
        .tsLogged(tsLog), .switchFault(swFault));

    initial forever #5 ref_clk = ~ref_clk;
    // Stripe transitions; a one-cycle jitter never crosses a threshold
    // Counted edge by edge, so a new speed takes hold at once
    initial forever begin
        @(posedge ref_clk);
        photoCnt = photoCnt + 1;
        if (photoCnt >= halfPer) begin
            photoCnt = -($random(seed) & 1);
            photoIn <= ~photoIn;
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, d);
        integer n;
        @(posedge ref_clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (hreadyOut !== 1'b1 && n < 20);
        if (n >= 20) begin err_count++; print_verdict; end
        htrans <= 2'h0; hwdata <= d;
        do begin @(posedge ref_clk); n++; end while (hreadyOut !== 1'b1 && n < 40);
        rd = hrdata;
        hsel <= 1'b0;
        if (n >= 40) begin err_count++; print_verdict; end
    endtask
    task automatic rel(input logic s, z);
        chk("speed relays", {30'h0, s, s}, {30'h0, spA, spB});
        chk("zone relays", {30'h0, z, z}, {30'h0, znA, znB});
    endtask
    // Model of the speed relay pair from the tracked tuning and fault state
    function automatic logic expSp(input integer over90);
        expSp = mOsT != 0 && enIn && (osCal || mOsF == 0) && !(mTsT != 0 && over90 != 0);
    endfunction
    task automatic spd(input integer h);
        halfPer = h;
        cyc(4 * h + 10);
    endtask
    task automatic press(input logic os);
        if (os) osRst <= 1'b1; else tsRst <= 1'b1;
        cyc(3);
        osRst <= 1'b0; tsRst <= 1'b0;
        cyc(4);
    endtask
    task automatic tune;
        xfer(1, 32'h04, 32'd20); xfer(1, 32'h08, 32'd60);
        xfer(1, 32'h0C, 32'd8); xfer(1, 32'h00, 32'h1);
        mOsT = 1; mTsT = 1; mOsF = 0;
    endtask

    initial begin repeat (20000) @(posedge ref_clk); err_count++; print_verdict; end
    initial begin
        cyc(8); rst_b <= 1'b1; normalMode <= 1'b1; enIn <= 1'b1;
        cyc(PWR + 10); rel(0, 0);
        xfer(0, 32'h0C, 0); chk("ts threshold", 32'h00FFFFFF, rd);
        xfer(0, 32'h40, 0); chk("unmapped", 32'h0, rd);
        tune;
        xfer(0, 32'h10, 0); chk("tuned bits", 32'h3, rd & 32'h3);
        cyc(5); rel(expSp(0), 1);
        spd(12); rel(expSp(0), 1); chk("lsm", 1, speed_flag_input);
        spd(30); chk("lsm", 1, speed_flag_input);
        spd(100); chk("lsm", 0, speed_flag_input);
        spd(5); rel(expSp(1), 1);
        tsCal <= 1'b1; upSw <= 1'b0; cyc(5); rel(expSp(1), 1);
        tsCal <= 1'b0; cyc(5); rel(0, 0); chk("ts trip", 1, tsTrip);
        spd(100); upSw <= 1'b1; rel(expSp(0), 0);
        normalMode <= 1'b0; inspMode <= 1'b1; press(0);
        chk("ts trip", 1, tsTrip);
        normalMode <= 1'b1; inspMode <= 1'b0; press(0);
        chk("ts trip", 0, tsTrip);
        normalMode <= 1'b0; inspMode <= 1'b1; checkOn <= 1'b1; cyc(5);
        rel(expSp(0), 0);
        spd(12); mOsF = 1; rel(expSp(0), 0);
        chk("os trip", 1, osTrip); chk("lsm", 1, speed_flag_input);
        chk("os log", 1, osLog); chk("ts log", 0, tsLog);
        checkOn <= 1'b0; spd(100); chk("lsm", 1, speed_flag_input);
        osCal <= 1'b1; cyc(5); rel(expSp(0), 0);
        osCal <= 1'b0; cyc(5); rel(expSp(0), 0);
        @(posedge ref_clk); storedOs <= osTrip; rst_b <= 1'b0;
        cyc(8); rst_b <= 1'b1; cyc(5); mOsT = 0; mTsT = 0;
        chk("os trip", 1, osTrip);
        press(1); chk("os trip", 0, osTrip);
        storedOs <= 1'b0; normalMode <= 1'b1; inspMode <= 1'b0; tune;
        cyc(PWR - 35); rel(0, 0);
        cyc(20); rel(expSp(0), 1);
        doorZone <= 1'b1; doorsClosed <= 1'b0; safeIn <= 1'b0;
        cyc(DOOR - 10); rel(1, 1);
        cyc(20); rel(1, 0);
        spd(12); chk("os trip", 1, osTrip);
        // Slow down first: a standing trip would win over the retune clear
        spd(100);
        xfer(1, 32'h04, 32'd20); cyc(3); chk("os trip", 0, osTrip);
        xfer(0, 32'h10, 0); chk("ts tuned", 32'h1, rd & 32'h3);
        atTerm <= 1'b1; upSw <= 1'b0; cyc(3);
        chk("sw fault", 0, swFault);
        upSw <= 1'b1; cyc(3);
        chk("sw fault", 1, swFault);
        print_verdict;
    end
endmodule
